//--- orpr_cfg.svh
// Constants for the over-range, init and power-mode register bank
// Function
// - Enable clear holds over-range pins low
// - Stretch pulse to four times two-to-exponent
// - Init status bit 0 shows completion
// - Mode two: 0x06 low, 0x0F high
// - Mode three: 0x00 low, 0x04 high
// - Mode four: 0x14 low, 0x1B high
// - Summary alarm register reads zero after reset
// - Over-range asserts when level reaches threshold
// - Alarm bit 0 shows unmasked pending alarm
`ifndef ORPR_CFG_SVH
`define ORPR_CFG_SVH
`define ORPR_ADDR_THRESH   12'h211
`define ORPR_ADDR_OVRCFG   12'h213
`define ORPR_ADDR_INIT     12'h270
`define ORPR_ADDR_PWR2     12'h29A
`define ORPR_ADDR_PWR3     12'h29B
`define ORPR_ADDR_PWR4     12'h29C
`define ORPR_ADDR_ALARM    12'h2C0
`define ORPR_RST_THRESH    8'hF2
`define ORPR_RST_OVRCFG    8'h07
`define ORPR_RST_PWR2      8'h0F
`define ORPR_RST_PWR3      8'h04
`define ORPR_RST_PWR4      8'h1B
`define ORPR_LOW_PWR2      8'h06
`define ORPR_LOW_PWR3      8'h00
`define ORPR_LOW_PWR4      8'h14
`define ORPR_EN_BIT        3
`define ORPR_EXP_MSB       2
`define ORPR_INIT_CYCLES   8'h10
`define ORPR_STRETCH_BASE  10'h004
`define ORPR_OVRCFG_EXP0   8'h08
`define ORPR_ZERO8         8'h00
`define ORPR_ONE8          8'h01
`endif

//--- orpr_pkg.sv
// Types for the over-range, init and power-mode register bank
package orpr_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } orpr_req_type;
  typedef enum logic [1:0] {
    ORPR_PWR_HIGH = 2'b00,
    ORPR_PWR_LOW  = 2'b01,
    ORPR_PWR_MIXED = 2'b10
  } orpr_pwr_type;
endpackage

//--- orpr_regs.sv
// Over-range output stretch, init status and power-mode registers
`timescale 1ns/1ps
`default_nettype none
`include "orpr_cfg.svh"
module orpr_regs
  import orpr_pkg::*;
(
  input  wire logic               MCLK,
  input  wire logic               SYS_RST,
  input  wire orpr_req_type       REG_REQ,
  input  wire logic [3:0][8:0]    CHAN_SAMPLE,
  input  wire logic               ALARM_PENDING,
  output logic [7:0]              REG_RDATA,
  output logic                    REG_RVALID,
  output logic [3:0]              OVR_OUT,
  output logic                    INIT_DONE,
  output logic [1:0]              POWER_MODE
);
  // ****************************************
  // Helpers
  // ****************************************
  // Absolute level of a 9-bit signed sample, saturated to 8 bits
  function automatic logic [7:0] abs_level(input logic [8:0] s);
    logic [8:0] m;
    m = s[8] ? (~s + 9'h001) : s;
    abs_level = (m[8] ? 8'hFF : m[7:0]);
  endfunction
  // Decode of three mode codes into one mode
  function automatic orpr_pwr_type mode_of(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] c);
    if (a == `ORPR_LOW_PWR2 && b == `ORPR_LOW_PWR3 && c == `ORPR_LOW_PWR4)
      mode_of = ORPR_PWR_LOW;
    else if (a == `ORPR_RST_PWR2 && b == `ORPR_RST_PWR3 && c == `ORPR_RST_PWR4)
      mode_of = ORPR_PWR_HIGH;
    else
      mode_of = ORPR_PWR_MIXED;
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] thresh_ff, nxt_thresh;
  logic [7:0] ovrcfg_ff, nxt_ovrcfg;
  logic [7:0] pwr2_ff, nxt_pwr2;
  logic [7:0] pwr3_ff, nxt_pwr3;
  logic [7:0] pwr4_ff, nxt_pwr4;
  logic [7:0] init_cnt_ff, nxt_init_cnt;
  logic       init_done_ff, nxt_init_done;
  logic       alarm_ff, nxt_alarm;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       rvalid_ff, nxt_rvalid;
  logic [1:0] mode_ff, nxt_mode;

  // Next values of writable registers and readback
  always_comb begin
    nxt_thresh = thresh_ff;
    nxt_ovrcfg = ovrcfg_ff;
    nxt_pwr2   = pwr2_ff;
    nxt_pwr3   = pwr3_ff;
    nxt_pwr4   = pwr4_ff;
    nxt_rdata  = `ORPR_ZERO8;
    nxt_rvalid = REG_REQ.rd;
    nxt_alarm  = ALARM_PENDING;
    nxt_init_cnt  = init_cnt_ff;
    nxt_init_done = init_done_ff;
    // Init sequencer counts down then raises done
    if (init_cnt_ff != `ORPR_ZERO8) begin
      nxt_init_cnt = init_cnt_ff - `ORPR_ONE8;
    end else begin
      nxt_init_done = 1'b1;
    end
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `ORPR_ADDR_THRESH: nxt_thresh = REG_REQ.wdata;
        `ORPR_ADDR_OVRCFG: nxt_ovrcfg = REG_REQ.wdata;
        `ORPR_ADDR_PWR2:   nxt_pwr2 = REG_REQ.wdata;
        `ORPR_ADDR_PWR3:   nxt_pwr3 = REG_REQ.wdata;
        `ORPR_ADDR_PWR4:   nxt_pwr4 = REG_REQ.wdata;
        default: ;
      endcase
    end
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `ORPR_ADDR_THRESH: nxt_rdata = thresh_ff;
        `ORPR_ADDR_OVRCFG: nxt_rdata = ovrcfg_ff;
        `ORPR_ADDR_INIT:   nxt_rdata = {7'h00, init_done_ff};
        `ORPR_ADDR_PWR2:   nxt_rdata = pwr2_ff;
        `ORPR_ADDR_PWR3:   nxt_rdata = pwr3_ff;
        `ORPR_ADDR_PWR4:   nxt_rdata = pwr4_ff;
        `ORPR_ADDR_ALARM:  nxt_rdata = {7'h00, alarm_ff};
        default:           nxt_rdata = `ORPR_ZERO8;
      endcase
    end
    nxt_mode = mode_of(pwr2_ff, pwr3_ff, pwr4_ff);
  end

  // Register stage of the register file
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      thresh_ff    <= `ORPR_RST_THRESH;
      ovrcfg_ff    <= `ORPR_RST_OVRCFG;
      pwr2_ff      <= `ORPR_RST_PWR2;
      pwr3_ff      <= `ORPR_RST_PWR3;
      pwr4_ff      <= `ORPR_RST_PWR4;
      init_cnt_ff  <= `ORPR_INIT_CYCLES;
      init_done_ff <= 1'b0;
      alarm_ff     <= 1'b0;
      rdata_ff     <= `ORPR_ZERO8;
      rvalid_ff    <= 1'b0;
      mode_ff      <= ORPR_PWR_HIGH;
    end else begin
      thresh_ff    <= nxt_thresh;
      ovrcfg_ff    <= nxt_ovrcfg;
      pwr2_ff      <= nxt_pwr2;
      pwr3_ff      <= nxt_pwr3;
      pwr4_ff      <= nxt_pwr4;
      init_cnt_ff  <= nxt_init_cnt;
      init_done_ff <= nxt_init_done;
      alarm_ff     <= nxt_alarm;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
      mode_ff      <= nxt_mode;
    end
  end

  // ****************************************
  // Over-range detect and stretch
  // ****************************************
  logic [9:0] hold_cnt_ff [4];
  logic [9:0] nxt_hold_cnt [4];
  logic [3:0] ovr_ff, nxt_ovr;
  logic [9:0] stretch_len;
  logic       overrange_output_enable;

  assign overrange_output_enable = ovrcfg_ff[`ORPR_EN_BIT];
  assign stretch_len = `ORPR_STRETCH_BASE << ovrcfg_ff[`ORPR_EXP_MSB:0];

  // Per-channel counter restarts on each crossing
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_hold_cnt[i] = hold_cnt_ff[i];
      if (abs_level(CHAN_SAMPLE[i]) >= thresh_ff) begin
        nxt_hold_cnt[i] = stretch_len;
      end else if (hold_cnt_ff[i] != 10'h000) begin
        nxt_hold_cnt[i] = hold_cnt_ff[i] - 10'h001;
      end
      nxt_ovr[i] = overrange_output_enable && (nxt_hold_cnt[i] != 10'h000);
    end
  end

  // Register stage of the stretch counters
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < 4; i++) begin
      if (SYS_RST) begin
        hold_cnt_ff[i] <= 10'h000;
      end else begin
        hold_cnt_ff[i] <= nxt_hold_cnt[i];
      end
    end
    if (SYS_RST) begin
      ovr_ff <= 4'h0;
    end else begin
      ovr_ff <= nxt_ovr;
    end
  end

  assign OVR_OUT    = ovr_ff;
  assign INIT_DONE  = init_done_ff;
  assign REG_RDATA  = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign POWER_MODE = mode_ff;

  // ****************************************
  // Assertions
  // ****************************************
  property p_ovr_low_when_off;
    @(posedge MCLK) disable iff (SYS_RST)
      !$past(overrange_output_enable) |-> (OVR_OUT == 4'h0);
  endproperty
  a_ovr_low_when_off: assert property (p_ovr_low_when_off)
    else $error("Over-range pin high while disabled");

  property p_min_stretch;
    @(posedge MCLK) disable iff (SYS_RST)
      ($rose(OVR_OUT[0]) && ovrcfg_ff == `ORPR_OVRCFG_EXP0 && $stable(ovrcfg_ff)) |->
        OVR_OUT[0] [*4];
  endproperty
  a_min_stretch: assert property (p_min_stretch)
    else $error("Over-range pulse shorter than minimum");

  property p_init_bit;
    @(posedge MCLK) disable iff (SYS_RST)
      (REG_REQ.rd && REG_REQ.addr == `ORPR_ADDR_INIT) |=>
        (REG_RDATA == {7'h00, $past(init_done_ff)});
  endproperty
  a_init_bit: assert property (p_init_bit)
    else $error("Init status readback wrong");

  property p_mode_low;
    @(posedge MCLK) disable iff (SYS_RST)
      (pwr2_ff == `ORPR_LOW_PWR2 && pwr3_ff == `ORPR_LOW_PWR3 && pwr4_ff == `ORPR_LOW_PWR4) |=>
        (POWER_MODE == ORPR_PWR_LOW);
  endproperty
  a_mode_low: assert property (p_mode_low)
    else $error("Low power mode not selected");

  property p_mode_high;
    @(posedge MCLK) disable iff (SYS_RST)
      (pwr2_ff == `ORPR_RST_PWR2 && pwr3_ff == `ORPR_RST_PWR3 && pwr4_ff == `ORPR_RST_PWR4) |=>
        (POWER_MODE == ORPR_PWR_HIGH);
  endproperty
  a_mode_high: assert property (p_mode_high)
    else $error("High performance mode not selected");

  property p_pwr4_write;
    @(posedge MCLK) disable iff (SYS_RST)
      (REG_REQ.wr && REG_REQ.addr == `ORPR_ADDR_PWR4) |=> (pwr4_ff == $past(REG_REQ.wdata));
  endproperty
  a_pwr4_write: assert property (p_pwr4_write)
    else $error("Mode four register not written");

  property p_alarm_read;
    @(posedge MCLK) disable iff (SYS_RST)
      (REG_REQ.rd && REG_REQ.addr == `ORPR_ADDR_ALARM) |=> (REG_RDATA[7:1] == 7'h00);
  endproperty
  a_alarm_read: assert property (p_alarm_read)
    else $error("Alarm reserved bits not zero");

  property p_threshold_hit;
    @(posedge MCLK) disable iff (SYS_RST)
      (overrange_output_enable && abs_level(CHAN_SAMPLE[1]) >= thresh_ff) |=> OVR_OUT[1];
  endproperty
  a_threshold_hit: assert property (p_threshold_hit)
    else $error("Crossing did not raise over-range");

  property p_alarm_follow;
    @(posedge MCLK) disable iff (SYS_RST)
      ALARM_PENDING [*2] |-> alarm_ff;
  endproperty
  a_alarm_follow: assert property (p_alarm_follow)
    else $error("Alarm bit not following pending alarm");

  property p_restart;
    @(posedge MCLK) disable iff (SYS_RST)
      (abs_level(CHAN_SAMPLE[2]) >= thresh_ff) |=> (hold_cnt_ff[2] == $past(stretch_len));
  endproperty
  a_restart: assert property (p_restart)
    else $error("Stretch counter not restarted");
endmodule
`default_nettype wire

//--- orpr_host_model.sv
// Host controller model that programs the register bank
`timescale 1ns/1ps
`default_nettype none
`include "orpr_cfg.svh"
module orpr_host_model
  import orpr_pkg::*;
(
  input  wire logic     MCLK,
  input  wire logic     INIT_DONE,
  output var orpr_req_type REG_REQ
);
  initial REG_REQ = '0;

  // ************************************************
  // One-cycle request strobe
  // ************************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [7:0] dv;
    dv = d;
    wait (INIT_DONE === 1'b1);
    if (a == `ORPR_ADDR_OVRCFG) dv = d & 8'h0F;
    @(negedge MCLK);
    REG_REQ = '{wr: w, rd: !w, addr: a, wdata: dv};
    @(negedge MCLK);
    REG_REQ = '0;
  endtask

  // Whole mode group, written in order two, three, then four
  task automatic set_mode(input logic low);
    xfer(1'b1, `ORPR_ADDR_PWR2, low ? `ORPR_LOW_PWR2 : `ORPR_RST_PWR2);
    xfer(1'b1, `ORPR_ADDR_PWR3, low ? `ORPR_LOW_PWR3 : `ORPR_RST_PWR3);
    xfer(1'b1, `ORPR_ADDR_PWR4, low ? `ORPR_LOW_PWR4 : `ORPR_RST_PWR4);
  endtask
endmodule
`default_nettype wire

//--- overrange_init_power_regs_tb_top.sv
// Testbench of the over-range, init and power-mode register bank
`timescale 1ns/1ps
`default_nettype none
`include "orpr_cfg.svh"
module overrange_init_power_regs_tb_top
  import orpr_pkg::*;
;
  logic            mclk;
  logic            sys_rst;
  orpr_req_type    reg_req;
  logic [3:0][8:0] chan_sample;
  logic            alarm_pending;
  logic [7:0]      reg_rdata;
  logic            reg_rvalid;
  logic [3:0]      ovr_out;
  logic            init_done;
  logic [1:0]      power_mode;
  logic [31:0]     seed;
  logic [15:0]     len;
  logic [7:0]      e;
  logic [7:0]      exp_q[$];
  int              errors;
  int              checked;

  orpr_regs dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .REG_REQ(reg_req),
    .CHAN_SAMPLE(chan_sample), .ALARM_PENDING(alarm_pending), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .OVR_OUT(ovr_out), .INIT_DONE(init_done),
    .POWER_MODE(power_mode));
  orpr_host_model host_u (.MCLK(mclk), .INIT_DONE(init_done), .REG_REQ(reg_req));

  // Clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read with its expected value noted first
  task automatic rd(input logic [11:0] a, input logic [7:0] ev);
    exp_q.push_back(ev);
    host_u.xfer(1'b0, a, 8'h00);
  endtask

  // Random low samples, crossing on one channel, count high cycles
  task automatic burst(input int ch, input int gap, input logic [8:0] lvl);
    len = '0;
    for (int i = 0; i < 600; i++) begin
      @(negedge mclk);
      seed = xs(seed);
      for (int c = 0; c < 4; c++) chan_sample[c] = {{4{seed[8*c+4]}}, seed[8*c+4 -: 5]};
      if (i == 0 || i == gap) chan_sample[ch] = lvl;
      if (ovr_out[ch] === 1'b1) len++;
    end
  endtask

  // Read data monitor
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({8'h00, reg_rdata}, {8'h00, e}, {8'h00, e});
    end
  end

  // Watchdog
  initial begin
    #2000000;
    errors++;
    stop_test();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    sys_rst = 1'b1;
    chan_sample = '0;
    alarm_pending = 1'b0;
    seed = 32'h8FE14873;
    errors = 0;
    checked = 0;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge mclk);
    check({15'h0000, init_done}, 16'h0001, 16'h0001);
    rd(`ORPR_ADDR_INIT, `ORPR_ONE8);
    host_u.xfer(1'b1, `ORPR_ADDR_INIT, 8'h00);
    rd(`ORPR_ADDR_INIT, `ORPR_ONE8);
    rd(`ORPR_ADDR_THRESH, `ORPR_RST_THRESH);
    rd(`ORPR_ADDR_OVRCFG, `ORPR_RST_OVRCFG);
    rd(`ORPR_ADDR_PWR2, `ORPR_RST_PWR2);
    rd(`ORPR_ADDR_PWR3, `ORPR_RST_PWR3);
    rd(`ORPR_ADDR_PWR4, `ORPR_RST_PWR4);
    host_u.xfer(1'b1, `ORPR_ADDR_ALARM, 8'hFF);
    rd(`ORPR_ADDR_ALARM, `ORPR_ZERO8);
    rd(12'h3FF, `ORPR_ZERO8);
    check({14'h0000, power_mode}, ORPR_PWR_HIGH, ORPR_PWR_HIGH);
    $display("test reset values done");
    host_u.set_mode(1'b1); // sampling clock far below 1 GSPS
    repeat (2) @(negedge mclk);
    check({14'h0000, power_mode}, ORPR_PWR_LOW, ORPR_PWR_LOW);
    host_u.xfer(1'b1, `ORPR_ADDR_PWR3, `ORPR_RST_PWR3);
    repeat (2) @(negedge mclk);
    check({14'h0000, power_mode}, ORPR_PWR_MIXED, ORPR_PWR_MIXED);
    host_u.set_mode(1'b0);
    repeat (2) @(negedge mclk);
    check({14'h0000, power_mode}, ORPR_PWR_HIGH, ORPR_PWR_HIGH);
    $display("test power modes done");
    alarm_pending = 1'b1;
    rd(`ORPR_ADDR_ALARM, `ORPR_ONE8);
    alarm_pending = 1'b0;
    rd(`ORPR_ADDR_ALARM, `ORPR_ZERO8);
    $display("test alarm done");
    host_u.xfer(1'b1, `ORPR_ADDR_THRESH, 8'h40);
    host_u.xfer(1'b1, `ORPR_ADDR_OVRCFG, 8'h00);
    burst(0, 0, 9'h040);
    check(len, 16'h0000, 16'h0000);
    for (int x = 0; x < 8; x++) begin
      host_u.xfer(1'b1, `ORPR_ADDR_OVRCFG, 8'h08 | 8'(x));
      burst(x % 4, 0, (x % 2) ? 9'h1C0 : 9'h040);
      check(len, 16'(4 << x), 16'((4 << x) + 1));
    end
    burst(2, 0, 9'h03F);
    check(len, 16'h0000, 16'h0000);
    host_u.xfer(1'b1, `ORPR_ADDR_OVRCFG, 8'h09);
    burst(1, 5, 9'h1C0);
    check(len, 16'd13, 16'd14);
    host_u.xfer(1'b1, `ORPR_ADDR_OVRCFG, 8'hF8);
    rd(`ORPR_ADDR_OVRCFG, 8'h08);
    $display("test over-range done");
    repeat (4) @(negedge mclk);
    check(16'(exp_q.size()), 16'h0000, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
